// File: hw/icfn_pkg.sv
// Constants and types shared by the convert/negate datapath
package icfn_pkg;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 8;
	localparam logic [7:0] FLAG_INEXACT = 8'h02;
	localparam logic [7:0] FLAG_INVALID = 8'h10;
	localparam logic [7:0] FLAG_FLUSHED = 8'h20;
	localparam logic [7:0] FLAG_MASK = 8'h32;
	localparam logic [7:0] PSW_FLAGS_RST = 8'h00;
	localparam logic [31:0] DEST_RST = 32'h00000000;
	localparam logic [31:0] INT_MIN = 32'h80000000;
	localparam logic [31:0] INT_MAX = 32'h7fffffff;
	localparam logic [7:0] EXP_BIAS = 8'h7f;
	localparam logic [7:0] EXP_INT_LIMIT = 8'h9e;
	localparam logic [7:0] EXP_ALL_ONES = 8'hff;
	// Rounding mode encodings
	typedef enum logic [1:0] {
		ICFN_RND_NEAREST = 2'h0,
		ICFN_RND_ZERO = 2'h1,
		ICFN_RND_POS = 2'h2,
		ICFN_RND_NEG = 2'h3
	} icfn_rnd_t;
	// Operation select
	typedef enum logic [2:0] {
		ICFN_OP_NONE = 3'h0,
		ICFN_OP_FIXRZ_FLAGS = 3'h1,
		ICFN_OP_FLIP = 3'h2,
		ICFN_OP_FLOAT = 3'h3,
		ICFN_OP_FLOAT_FLAGS = 3'h4
	} icfn_op_t;
endpackage

// File: hw/icfn_conv_if.sv
// Interface between the top and the conversion core
`timescale 1ns/1ps
interface icfn_conv_if;
	logic [31:0] src;
	logic [1:0] rnd;
	logic [31:0] fix_flags;
	logic [31:0] flt_value;
	logic [7:0] flt_flags;
	modport top (output src, output rnd, input fix_flags, input flt_value,
		input flt_flags);
	modport core (input src, input rnd, output fix_flags, output flt_value,
		output flt_flags);
endinterface

// File: hw/icfn_conv.sv
// Combinational float/int conversion core
`timescale 1ns/1ps
module icfn_conv (
	icfn_conv_if.core cv
);
	logic [31:0] mag;
	logic [4:0] msb;
	logic [31:0] norm;
	logic [7:0] exp_f;
	logic [22:0] mant;
	logic guard_bit;
	logic sticky;
	logic round_up;
	logic [31:0] rounded;
	logic sgn;
	logic [7:0] fexp;
	logic [22:0] ffrac;
	logic [7:0] fix_fl;

	function automatic logic [4:0] lead_one(input logic [31:0] v);
		logic [4:0] p;
		p = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				p = 5'(i);
			end
		end
		return p;
	endfunction

	// Integer to float with status rounding mode
	always_comb begin
		sgn = cv.src[31];
		mag = sgn ? (~cv.src + 32'h00000001) : cv.src;
		msb = lead_one(mag);
		norm = mag << (5'h1f - msb);
		mant = norm[30:8];
		guard_bit = norm[7];
		sticky = |norm[6:0];
		unique case (icfn_pkg::icfn_rnd_t'(cv.rnd))
			icfn_pkg::ICFN_RND_NEAREST: round_up = guard_bit & (sticky | mant[0]);
			icfn_pkg::ICFN_RND_ZERO: round_up = 1'b0;
			icfn_pkg::ICFN_RND_POS: round_up = ~sgn & (guard_bit | sticky);
			icfn_pkg::ICFN_RND_NEG: round_up = sgn & (guard_bit | sticky);
		endcase
		exp_f = icfn_pkg::EXP_BIAS + 8'(msb);
		rounded = {1'b0, exp_f, mant} + {31'h00000000, round_up};
		cv.flt_value = (mag == 32'h00000000) ? icfn_pkg::DEST_RST :
			{sgn, rounded[30:0]};
		cv.flt_flags = (guard_bit | sticky) ? icfn_pkg::FLAG_INEXACT : 8'h00;
	end

	// Float to integer flags, always toward zero
	// mode bits never read
	always_comb begin
		fexp = cv.src[30:23];
		ffrac = cv.src[22:0];
		fix_fl = 8'h00;
		if (fexp == icfn_pkg::EXP_ALL_ONES) begin
			fix_fl = icfn_pkg::FLAG_INVALID;
		end else if (fexp == 8'h00) begin
			if (ffrac != 23'h000000) begin
				fix_fl = icfn_pkg::FLAG_FLUSHED;
			end
		end else if (fexp >= icfn_pkg::EXP_INT_LIMIT) begin
			// Only -2^31 exactly fits at the limit exponent
			if (!(cv.src[31] && fexp == icfn_pkg::EXP_INT_LIMIT &&
				ffrac == 23'h000000)) begin
				fix_fl = icfn_pkg::FLAG_INVALID;
			end
		end else if (fexp < icfn_pkg::EXP_BIAS) begin
			fix_fl = icfn_pkg::FLAG_INEXACT;
		end else if (fexp - icfn_pkg::EXP_BIAS < 8'h17) begin
			if ((({9'h000, ffrac} << 5'(fexp - icfn_pkg::EXP_BIAS)) &
				32'h007fffff) != 32'h00000000) begin
				fix_fl = icfn_pkg::FLAG_INEXACT;
			end
		end
		cv.fix_flags = {24'h000000, fix_fl};
	end
endmodule

// File: hw/icfn_top.sv
// Convert and conditional-negate datapath with sticky status flags
`timescale 1ns/1ps
module icfn_top (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic ISSUE,
	input wire logic [2:0] OPCODE,
	input wire logic [31:0] SRC_REG_A,
	input wire logic [31:0] SRC_REG_B,
	input wire logic GUARD,
	input wire logic [1:0] RND_MODE,
	input wire logic [7:0] EXT_FLAG_UPDATE,
	input wire logic PSW_WRITE,
	input wire logic [7:0] PSW_WRITE_DATA,
	output logic DEST_WE,
	output logic [31:0] DEST_DATA,
	output logic [7:0] PROC_STATUS_WORD
);
	icfn_conv_if cv ();
	logic dest_we_reg, dest_we_next;
	logic [31:0] dest_reg, dest_next;
	logic [7:0] psw_reg, psw_next;
	logic [7:0] upd;
	logic go;

	assign cv.src = SRC_REG_A;
	assign cv.rnd = RND_MODE;

	icfn_conv u_conv (
		.cv(cv)
	);

	always_comb begin
		// Guard gates every destination write; status writes and external flag updates are not gated
		// guard gate
		go = ISSUE & GUARD;
		dest_we_next = 1'b0;
		dest_next = dest_reg;
		upd = 8'h00;
		if (go) begin
			unique case (icfn_pkg::icfn_op_t'(OPCODE))
				icfn_pkg::ICFN_OP_FIXRZ_FLAGS: begin
					dest_next = cv.fix_flags;
					dest_we_next = 1'b1;
				end
				icfn_pkg::ICFN_OP_FLIP: begin
					dest_next = (SRC_REG_A == 32'h00000000) ? SRC_REG_B :
						(~SRC_REG_B + 32'h00000001);
					dest_we_next = 1'b1;
				end
				icfn_pkg::ICFN_OP_FLOAT: begin
					dest_next = cv.flt_value;
					dest_we_next = 1'b1;
					upd = cv.flt_flags;
				end
				icfn_pkg::ICFN_OP_FLOAT_FLAGS: begin
					dest_next = {24'h000000, cv.flt_flags};
					dest_we_next = 1'b1;
				end
				default: begin
					dest_we_next = 1'b0;
				end
			endcase
		end
		psw_next = psw_reg | ((upd | EXT_FLAG_UPDATE) & icfn_pkg::FLAG_MASK);
		if (PSW_WRITE) begin
			psw_next = (PSW_WRITE_DATA & icfn_pkg::FLAG_MASK) |
				((upd | EXT_FLAG_UPDATE) & icfn_pkg::FLAG_MASK);
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			dest_we_reg <= 1'b0;
			dest_reg <= icfn_pkg::DEST_RST;
			psw_reg <= icfn_pkg::PSW_FLAGS_RST;
		end else begin
			dest_we_reg <= dest_we_next;
			dest_reg <= dest_next;
			psw_reg <= psw_next;
		end
	end

	assign DEST_WE = dest_we_reg;
	assign DEST_DATA = dest_reg;
	assign PROC_STATUS_WORD = psw_reg;

	property p_guard_blocks;
		@(posedge CLK) disable iff (!RST_B)
		(ISSUE && !GUARD) |=> !DEST_WE;
	endproperty
	a_guard_blocks: assert property (p_guard_blocks)
		else $error("write despite false guard");

	property p_flip_copy;
		@(posedge CLK) disable iff (!RST_B)
		(go && OPCODE == 3'h2 && SRC_REG_A == 32'h0) |=>
			DEST_DATA == $past(SRC_REG_B);
	endproperty
	a_flip_copy: assert property (p_flip_copy)
		else $error("flip copy wrong");

	property p_flip_neg;
		@(posedge CLK) disable iff (!RST_B)
		(go && OPCODE == 3'h2 && SRC_REG_A != 32'h0) |=>
			DEST_DATA + $past(SRC_REG_B) == 32'h0;
	endproperty
	a_flip_neg: assert property (p_flip_neg)
		else $error("flip negate wrong");

	property p_flags_only_keep;
		@(posedge CLK) disable iff (!RST_B)
		(go && (OPCODE == 3'h1 || OPCODE == 3'h4) && !PSW_WRITE &&
			EXT_FLAG_UPDATE == 8'h0) |=> $stable(PROC_STATUS_WORD);
	endproperty
	a_flags_only_keep: assert property (p_flags_only_keep)
		else $error("flag-only op changed status");

	property p_sticky;
		@(posedge CLK) disable iff (!RST_B)
		!PSW_WRITE |=> ((PROC_STATUS_WORD & $past(PROC_STATUS_WORD)) ==
			$past(PROC_STATUS_WORD));
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag cleared without status write");

	property p_or_merge;
		@(posedge CLK) disable iff (!RST_B)
		!PSW_WRITE |=> ((PROC_STATUS_WORD & $past(EXT_FLAG_UPDATE) &
			icfn_pkg::FLAG_MASK) == ($past(EXT_FLAG_UPDATE) &
			icfn_pkg::FLAG_MASK));
	endproperty
	a_or_merge: assert property (p_or_merge)
		else $error("simultaneous update lost");

	sequence s_float_issue;
		go && OPCODE == 3'h3 && cv.flt_flags != 8'h0;
	endsequence
	property p_float_flags;
		@(posedge CLK) disable iff (!RST_B)
		s_float_issue |=> DEST_WE && (PROC_STATUS_WORD &
			icfn_pkg::FLAG_INEXACT) != 8'h0;
	endproperty
	a_float_flags: assert property (p_float_flags)
		else $error("status not updated with destination");

	property p_float_guard;
		@(posedge CLK) disable iff (!RST_B)
		(ISSUE && !GUARD && OPCODE == 3'h3 && !PSW_WRITE &&
			EXT_FLAG_UPDATE == 8'h0) |=> $stable(PROC_STATUS_WORD);
	endproperty
	a_float_guard: assert property (p_float_guard)
		else $error("guarded float touched status");

	property p_flag_layout;
		@(posedge CLK) disable iff (!RST_B)
		(go && OPCODE == 3'h1) |=> (DEST_DATA & ~32'h32) == 32'h0;
	endproperty
	a_flag_layout: assert property (p_flag_layout)
		else $error("flag vector outside layout");

	property p_denorm;
		@(posedge CLK) disable iff (!RST_B)
		(go && OPCODE == 3'h1 && SRC_REG_A[30:23] == 8'h0 &&
			SRC_REG_A[22:0] != 23'h0) |=> DEST_DATA == 32'h20;
	endproperty
	a_denorm: assert property (p_denorm)
		else $error("denormal not flushed");

	property p_rz_mode;
		@(posedge CLK) disable iff (!RST_B)
		(go && OPCODE == 3'h1 && SRC_REG_A == 32'h40247ae1) |=>
			DEST_DATA == 32'h02;
	endproperty
	a_rz_mode: assert property (p_rz_mode)
		else $error("truncating flags depend on mode");

	property p_data_hold;
		@(posedge CLK) disable iff (!RST_B)
		!DEST_WE |-> $stable(DEST_DATA);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("destination changed without write");

	property p_write_cause;
		@(posedge CLK) disable iff (!RST_B)
		DEST_WE |-> $past(go) && $past(OPCODE) >= 3'h1 &&
			$past(OPCODE) <= 3'h4;
	endproperty
	a_write_cause: assert property (p_write_cause)
		else $error("write without guarded issue");

	sequence s_psw_write;
		PSW_WRITE && EXT_FLAG_UPDATE == 8'h0 && !go;
	endsequence
	property p_psw_write;
		@(posedge CLK) disable iff (!RST_B)
		s_psw_write |=> PROC_STATUS_WORD ==
			($past(PSW_WRITE_DATA) & icfn_pkg::FLAG_MASK);
	endproperty
	a_psw_write: assert property (p_psw_write)
		else $error("status write not applied");
endmodule

// File: testbench/icfn_issue_model.sv
// Issue stage of the core that feeds the datapath its operands
`timescale 1ns/1ps
module icfn_issue_model (
	input wire logic CLK,
	output logic ISSUE,
	output logic [2:0] OPCODE,
	output logic [31:0] SRC_REG_A,
	output logic [31:0] SRC_REG_B,
	output logic GUARD,
	output logic [1:0] RND_MODE
);
	initial begin
		ISSUE = 1'b0;
		OPCODE = 3'h0;
		SRC_REG_A = 32'h0;
		SRC_REG_B = 32'h0;
		GUARD = 1'b0;
		RND_MODE = 2'h0;
	end
	// Caller stands at a falling edge; holds one cycle, then scrambles
	task automatic issue(input logic [2:0] op, input logic [31:0] a,
		input logic [31:0] b, input logic g, input logic [1:0] m);
		ISSUE = 1'b1;
		OPCODE = op;
		SRC_REG_A = a;
		SRC_REG_B = b;
		GUARD = g;
		RND_MODE = m;
		@(negedge CLK);
		ISSUE = 1'b0;
		// Stale operands must not look valid once the slot is gone
		SRC_REG_A = ~a;
		SRC_REG_B = ~b;
		GUARD = ~g;
	endtask
endmodule

// File: testbench/test_icfn_top.sv
// Self-checking bench for the convert and conditional-negate datapath
`timescale 1ns/1ps
module test_icfn_top;
	logic CLK, RST_B, ISSUE, GUARD, PSW_WRITE, DEST_WE;
	logic [2:0] OPCODE;
	logic [31:0] SRC_REG_A, SRC_REG_B, DEST_DATA;
	logic [1:0] RND_MODE;
	logic [7:0] EXT_FLAG_UPDATE, PSW_WRITE_DATA, PROC_STATUS_WORD;
	icfn_pkg::icfn_op_t cur;
	int error_cnt = 0;
	int compares = 0;
	icfn_top dut (.CLK(CLK), .RST_B(RST_B), .ISSUE(ISSUE),
		.OPCODE(OPCODE), .SRC_REG_A(SRC_REG_A), .SRC_REG_B(SRC_REG_B),
		.GUARD(GUARD), .RND_MODE(RND_MODE),
		.EXT_FLAG_UPDATE(EXT_FLAG_UPDATE), .PSW_WRITE(PSW_WRITE),
		.PSW_WRITE_DATA(PSW_WRITE_DATA), .DEST_WE(DEST_WE),
		.DEST_DATA(DEST_DATA), .PROC_STATUS_WORD(PROC_STATUS_WORD));
	icfn_issue_model core (.CLK(CLK), .ISSUE(ISSUE), .OPCODE(OPCODE),
		.SRC_REG_A(SRC_REG_A), .SRC_REG_B(SRC_REG_B), .GUARD(GUARD),
		.RND_MODE(RND_MODE));
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One op of kind cur; the answer stands at the take edge and is checked half a cycle later
	task automatic op(input logic [31:0] a, input logic [31:0] b,
		input logic g, input logic [1:0] m, input logic [31:0] d,
		input logic [7:0] psw);
		core.issue(cur, a, b, g, m);
		chk("write", {31'h0, DEST_WE}, {31'h0, g});
		chk("data", DEST_DATA, d);
		chk("status", {24'h0, PROC_STATUS_WORD}, {24'h0, psw});
		// Idle slot: strobe stays low across one edge between ops
		@(negedge CLK);
		chk("write end", {31'h0, DEST_WE}, 32'h0);
		chk("data hold", DEST_DATA, d);
	endtask
	task automatic t_fix;
		cur = icfn_pkg::ICFN_OP_FIXRZ_FLAGS;
		op(32'h40400000, 32'h0, 1'b1, 2'h0, 32'h0, 8'h0);
		op(32'h40247ae1, 32'h0, 1'b1, 2'h2, 32'h2, 8'h0);
		op(32'hff4fffff, 32'h0, 1'b1, 2'h0, 32'h10, 8'h0);
		op(32'h7f800000, 32'h0, 1'b1, 2'h0, 32'h10, 8'h0);
		op(32'hbfc147ae, 32'h0, 1'b1, 2'h3, 32'h2, 8'h0);
		op(32'h00400000, 32'h0, 1'b1, 2'h0, 32'h20, 8'h0);
		op(32'hffbfffff, 32'h0, 1'b1, 2'h0, 32'h10, 8'h0);
	endtask
	task automatic t_flip;
		cur = icfn_pkg::ICFN_OP_FLIP;
		op(32'h0, 32'h1, 1'b1, 2'h0, 32'h1, 8'h0);
		op(32'hffff0000, 32'habc, 1'b0, 2'h0, 32'h1, 8'h0);
		op(32'hffff0000, 32'habc, 1'b1, 2'h0, 32'hfffff544, 8'h0);
		op(32'h0, 32'hffffff9c, 1'b1, 2'h0, 32'hffffff9c, 8'h0);
		op(32'h1, 32'hffffffff, 1'b1, 2'h0, 32'h1, 8'h0);
	endtask
	// Unused opcode with a true guard must be refused
	task automatic t_noop;
		core.issue(3'h5, 32'h1, 32'h7, 1'b1, 2'h0);
		chk("noop write", {31'h0, DEST_WE}, 32'h0);
		chk("noop data", DEST_DATA, 32'h1);
		@(negedge CLK);
	endtask
	task automatic t_float;
		cur = icfn_pkg::ICFN_OP_FLOAT_FLAGS;
		op(32'h7fffffff, 32'h0, 1'b1, 2'h1, 32'h2, 8'h0);
		op(32'h80000000, 32'h0, 1'b1, 2'h0, 32'h0, 8'h0);
		cur = icfn_pkg::ICFN_OP_FLOAT;
		op(32'h3, 32'h0, 1'b1, 2'h0, 32'h40400000, 8'h0);
		op(32'hffffffff, 32'h0, 1'b1, 2'h0, 32'hbf800000, 8'h0);
		op(32'h7fffffff, 32'h0, 1'b0, 2'h0, 32'hbf800000, 8'h0);
		op(32'h7fffffff, 32'h0, 1'b1, 2'h1, 32'h4effffff, 8'h2);
		op(32'h7ffffff1, 32'h0, 1'b1, 2'h0, 32'h4f000000, 8'h2);
		op(32'h80000001, 32'h0, 1'b1, 2'h2, 32'hceffffff, 8'h2);
		op(32'h80000001, 32'h0, 1'b1, 2'h3, 32'hcf000000, 8'h2);
		op(32'h3, 32'h0, 1'b1, 2'h0, 32'h40400000, 8'h2);
	endtask
	task automatic t_psw;
		PSW_WRITE = 1'b1;
		PSW_WRITE_DATA = 8'hff;
		@(negedge CLK);
		chk("status mask", {24'h0, PROC_STATUS_WORD}, 32'h32);
		PSW_WRITE_DATA = 8'h00;
		@(negedge CLK);
		PSW_WRITE = 1'b0;
		chk("status", {24'h0, PROC_STATUS_WORD}, 32'h0);
		cur = icfn_pkg::ICFN_OP_FLOAT;
		EXT_FLAG_UPDATE = 8'h10;
		op(32'h7fffffff, 32'h0, 1'b1, 2'h0, 32'h4f000000, 8'h12);
		EXT_FLAG_UPDATE = 8'h00;
		cur = icfn_pkg::ICFN_OP_FIXRZ_FLAGS;
		op(32'h00400000, 32'h0, 1'b1, 2'h0, 32'h20, 8'h12);
		// A flag raised during a clearing write survives it
		PSW_WRITE = 1'b1;
		EXT_FLAG_UPDATE = 8'h20;
		@(negedge CLK);
		PSW_WRITE = 1'b0;
		EXT_FLAG_UPDATE = 8'h00;
		chk("status set", {24'h0, PROC_STATUS_WORD}, 32'h20);
	endtask
	// Mid-run reset clears everything, then ops run again
	task automatic t_reset;
		RST_B = 1'b0;
		@(negedge CLK);
		chk("rst write", {31'h0, DEST_WE}, 32'h0);
		chk("rst data", DEST_DATA, 32'h0);
		chk("rst status", {24'h0, PROC_STATUS_WORD}, 32'h0);
		RST_B = 1'b1;
		cur = icfn_pkg::ICFN_OP_FLIP;
		op(32'h1, 32'h2, 1'b1, 2'h0, 32'hfffffffe, 8'h0);
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Hang guard: the whole sequence needs far fewer cycles
	initial begin
		#80000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		RST_B = 1'b0;
		EXT_FLAG_UPDATE = 8'h00;
		PSW_WRITE = 1'b0;
		PSW_WRITE_DATA = 8'h00;
		repeat (16) @(negedge CLK);
		chk("reset data", DEST_DATA, 32'h0);
		chk("reset status", {24'h0, PROC_STATUS_WORD}, 32'h0);
		RST_B = 1'b1;
		t_fix();
		t_flip();
		t_noop();
		t_float();
		t_psw();
		t_reset();
		end_of_test();
	end
endmodule
